// file: src/cdm_regs.svh
`ifndef CDM_REGS_SVH
`define CDM_REGS_SVH

// register byte offsets
`define CDM_OFS_CTRL 8'h00
`define CDM_OFS_INTS 8'h04
`define CDM_OFS_IE 8'h08
`define CDM_OFS_LEC 8'h0c
`define CDM_OFS_ERC 8'h10
`define CDM_OFS_TRQ 8'h14
`define CDM_OFS_RXD 8'h18

// module_control_reg fields
`define CDM_CTRL_MODE_LSB 0
`define CDM_CTRL_AL_BIT 3
`define CDM_CTRL_VALID_BIT 8
`define CDM_CTRL_RXNE_BIT 9

// int_status_reg / int_enable_reg fields
`define CDM_INT_TXDONE_BIT 0
`define CDM_INT_PERR_BIT 3
`define CDM_INT_ARBL_BIT 4
`define CDM_INT_W 5

// error_counter_reg fields
`define CDM_ERC_BUSOFF_BIT 8

// reset values
`define CDM_INTS_RST 5'h00
`define CDM_IE_RST 5'h00
`define CDM_LEC_RST 3'h0
`define CDM_TEC_RST 8'h00
`define CDM_TRQ_RST 4'h0

// counts and sizes
`define CDM_TEC_ERR_STEP 8'h08
`define CDM_TEC_MAX 8'hff
`define CDM_NBUF 4
`define CDM_FIFO_W 32
`define CDM_FIFO_D 8

`endif

// file: src/cdm_pkg.sv
package cdm_pkg;

  // gray order along init -> normal -> abt ... -> self-test
  typedef enum logic [2:0]
  {
    cdm_init = 3'h0,
    cdm_normal = 3'h1,
    cdm_normal_abt = 3'h3,
    cdm_single = 3'h2,
    cdm_rx_only = 3'h6,
    cdm_self_test = 3'h7
  } cdm_mode_t;

  typedef logic [2:0] cdm_lec_t;

endpackage

// file: src/cdm_fifo.sv
`timescale 1ns/1ps
module cdm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW-1:0] head_next;
  logic [AW:0] count_next;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign head_next = pop ? rd_ptr + 1'b1 : rd_ptr;
  assign count_next = count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= head_next;
      count <= count_next;
      in_ready <= count_next != DEPTH[AW:0];
      out_valid <= count_next != '0;
      // registered head, bypassing a word written into the slot that becomes the head
      out_data <= (push && wr_ptr == head_next) ? in_data : mem[head_next];
    end
  end
endmodule // cdm_fifo

// file: src/cdm_diag.sv
`timescale 1ns/1ps
`include "cdm_regs.svh"
module cdm_diag (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_tx_pin,
  input wire logic bus_rx_pin,
  input wire logic core_tx_bit,
  input wire logic core_ack_slot,
  output logic core_rx_bit,
  input wire logic ev_tx_ok,
  input wire logic ev_arb_loss,
  input wire logic ev_error,
  input wire cdm_pkg::cdm_lec_t ev_err_code,
  input wire logic [1:0] ev_buf,
  input wire logic ev_rx_good,
  input wire logic rx_word_valid,
  input wire logic [31:0] rx_word,
  output logic rx_word_ready,
  output logic tx_enable,
  output logic retry_arb_enable,
  output logic retry_err_enable,
  output logic store_enable,
  output logic abt_enable,
  output logic [3:0] transmit_request_flag,
  output logic bus_off,
  output logic tx_irq,
  input wire logic sleep_active,
  input wire logic rx_pin_is_port,
  output logic wake_pulse
);
  import cdm_pkg::*;

  cdm_mode_t mode_reg;
  logic arb_loss_retry_enable;
  logic valid_reg;
  logic [`CDM_INT_W-1:0] int_status_reg;
  logic [`CDM_INT_W-1:0] int_enable_reg;
  cdm_lec_t last_error_code;
  logic [7:0] tx_error_count;
  logic rx_pin_prev;
  logic fifo_valid;
  logic [31:0] fifo_data;
  logic access;
  logic done;
  logic wr_en;
  logic [3:0] sw_trq_set;
  logic [3:0] hw_trq_clr;
  logic perr_ev;

  // transmit-type activity allowed in this mode
  function automatic logic tx_mode(input cdm_mode_t m);
    tx_mode = (m == cdm_normal) || (m == cdm_normal_abt) || (m == cdm_single)
      || (m == cdm_self_test);
  endfunction

  // retry permission after arbitration loss or error
  function automatic logic retry_ok(input cdm_mode_t m, input logic al, input logic arb);
    if (m == cdm_single)
    begin
      retry_ok = arb & al;
    end
    else
    begin
      retry_ok = tx_mode(m);
    end
  endfunction

  function automatic logic is_proto_err(input cdm_lec_t c);
    is_proto_err = (c >= 3'h1) && (c <= 3'h5);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `CDM_OFS_CTRL) || (a == `CDM_OFS_INTS) || (a == `CDM_OFS_IE)
      || (a == `CDM_OFS_LEC) || (a == `CDM_OFS_ERC) || (a == `CDM_OFS_TRQ)
      || (a == `CDM_OFS_RXD);
  endfunction

  assign access = psel & penable;
  assign done = access & pready;
  assign wr_en = done & pwrite;
  assign perr_ev = ev_error & is_proto_err(ev_err_code);
  assign sw_trq_set = (wr_en && paddr == `CDM_OFS_TRQ) ? pwdata[3:0] : 4'h0;

  always_comb
  begin
    hw_trq_clr = 4'h0;
    if (ev_tx_ok && tx_mode(mode_reg))
    begin
      hw_trq_clr[ev_buf] = 1'b1;
    end
    if (ev_arb_loss && !retry_ok(mode_reg, arb_loss_retry_enable, 1'b1) && tx_mode(mode_reg))
    begin
      hw_trq_clr[ev_buf] = 1'b1;
    end
    if (ev_error && !retry_ok(mode_reg, arb_loss_retry_enable, 1'b0) && tx_mode(mode_reg))
    begin
      hw_trq_clr[ev_buf] = 1'b1;
    end
  end

  // apb slave: one wait state, then pready
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped(paddr);
      if (access && !pready && !pwrite)
      begin
        case (paddr)
          `CDM_OFS_CTRL: prdata <= {22'h0, fifo_valid, valid_reg, 4'h0,
            arb_loss_retry_enable, mode_reg};
          `CDM_OFS_INTS: prdata <= {27'h0, int_status_reg};
          `CDM_OFS_IE: prdata <= {27'h0, int_enable_reg};
          `CDM_OFS_LEC: prdata <= {29'h0, last_error_code};
          `CDM_OFS_ERC: prdata <= {23'h0, bus_off, tx_error_count};
          `CDM_OFS_TRQ: prdata <= {28'h0, transmit_request_flag};
          `CDM_OFS_RXD: prdata <= fifo_valid ? fifo_data : 32'h0;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // mode selection and arbitration-loss retry bit
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_reg <= cdm_init;
      arb_loss_retry_enable <= 1'b0;
    end
    else if (wr_en && paddr == `CDM_OFS_CTRL)
    begin
      arb_loss_retry_enable <= pwdata[`CDM_CTRL_AL_BIT];
      case (pwdata[2:0])
        3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7: mode_reg <= cdm_mode_t'(pwdata[2:0]);
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // valid flag: set wins over write-one clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      valid_reg <= 1'b0;
    end
    else if (ev_rx_good && mode_reg != cdm_init)
    begin
      valid_reg <= 1'b1;
    end
    else if (wr_en && paddr == `CDM_OFS_CTRL && pwdata[`CDM_CTRL_VALID_BIT])
    begin
      valid_reg <= 1'b0;
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      int_status_reg <= `CDM_INTS_RST;
    end
    else
    begin
      for (int i = 0; i < `CDM_INT_W; i++)
      begin
        if (wr_en && paddr == `CDM_OFS_INTS && pwdata[i])
        begin
          int_status_reg[i] <= 1'b0;
        end
      end
      if (ev_tx_ok && tx_mode(mode_reg))
      begin
        int_status_reg[`CDM_INT_TXDONE_BIT] <= 1'b1;
      end
      if (perr_ev && mode_reg != cdm_init)
      begin
        int_status_reg[`CDM_INT_PERR_BIT] <= 1'b1;
      end
      if (ev_arb_loss && tx_mode(mode_reg))
      begin
        int_status_reg[`CDM_INT_ARBL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      int_enable_reg <= `CDM_IE_RST;
    end
    else if (wr_en && paddr == `CDM_OFS_IE)
    begin
      int_enable_reg <= pwdata[`CDM_INT_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= int_status_reg[`CDM_INT_TXDONE_BIT] & int_enable_reg[`CDM_INT_TXDONE_BIT];
    end
  end

  // last error code, hardware write wins over software clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      last_error_code <= `CDM_LEC_RST;
    end
    else if (ev_error && mode_reg != cdm_init)
    begin
      last_error_code <= ev_err_code;
    end
    else if (wr_en && paddr == `CDM_OFS_LEC)
    begin
      last_error_code <= `CDM_LEC_RST;
    end
  end

  // transmit error counter, frozen where nothing may be sent
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_error_count <= `CDM_TEC_RST;
      bus_off <= 1'b0;
    end
    else if (mode_reg == cdm_init)
    begin
      bus_off <= 1'b0;
    end
    else if (tx_mode(mode_reg))
    begin
      if (ev_error)
      begin
        if (tx_error_count > `CDM_TEC_MAX - `CDM_TEC_ERR_STEP)
        begin
          tx_error_count <= `CDM_TEC_MAX;
          bus_off <= 1'b1;
        end
        else
        begin
          tx_error_count <= tx_error_count + `CDM_TEC_ERR_STEP;
        end
      end
      else if (ev_tx_ok && tx_error_count != 8'h00)
      begin
        tx_error_count <= tx_error_count - 8'h01;
      end
    end
  end

  // transmit request flags: software sets, hardware clears
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      transmit_request_flag <= `CDM_TRQ_RST;
    end
    else
    begin
      transmit_request_flag <= (transmit_request_flag & ~hw_trq_clr) | sw_trq_set;
    end
  end

  // per-mode permissions to the protocol core
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_enable <= 1'b0;
      retry_arb_enable <= 1'b0;
      retry_err_enable <= 1'b0;
      store_enable <= 1'b0;
      abt_enable <= 1'b0;
    end
    else
    begin
      tx_enable <= tx_mode(mode_reg);
      retry_arb_enable <= retry_ok(mode_reg, arb_loss_retry_enable, 1'b1);
      retry_err_enable <= retry_ok(mode_reg, arb_loss_retry_enable, 1'b0);
      store_enable <= mode_reg != cdm_init;
      abt_enable <= mode_reg == cdm_normal_abt;
    end
  end

  // pin path: recessive pin in rx-only, self-test and init
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bus_tx_pin <= 1'b1;
      core_rx_bit <= 1'b1;
    end
    else
    begin
      bus_tx_pin <= tx_mode(mode_reg) && mode_reg != cdm_self_test ? core_tx_bit : 1'b1;
      if (mode_reg == cdm_self_test)
      begin
        core_rx_bit <= core_tx_bit;
      end
      else if (mode_reg == cdm_rx_only && core_ack_slot)
      begin
        core_rx_bit <= 1'b0;
      end
      else
      begin
        core_rx_bit <= bus_rx_pin;
      end
    end
  end

  // wake on falling receive edge, in every mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_pin_prev <= 1'b1;
      wake_pulse <= 1'b0;
    end
    else
    begin
      rx_pin_prev <= bus_rx_pin;
      wake_pulse <= sleep_active & ~rx_pin_is_port & rx_pin_prev & ~bus_rx_pin;
    end
  end

  cdm_fifo #(
    .WIDTH(`CDM_FIFO_W),
    .DEPTH(`CDM_FIFO_D)
  ) u_rx_fifo (
    .clk(mclk),
    .rst(rst),
    .in_valid(rx_word_valid & store_enable),
    .in_ready(rx_word_ready),
    .in_data(rx_word),
    .out_valid(fifo_valid),
    .out_ready(done & ~pwrite & (paddr == `CDM_OFS_RXD)),
    .out_data(fifo_data)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  pin_recessive_a: assert property (
    mode_reg inside {cdm_rx_only, cdm_self_test, cdm_init} |=> bus_tx_pin)
    else $error("tx pin driven in silent mode");
  tec_frozen_a: assert property (
    mode_reg == cdm_rx_only |=> $stable(tx_error_count))
    else $error("error count moved in rx-only");
  no_tx_a: assert property (
    mode_reg == cdm_rx_only && $past(mode_reg) == cdm_rx_only |-> !tx_enable)
    else $error("transmit enabled in rx-only");
  single_clear_a: assert property (
    mode_reg == cdm_single && (ev_error || ev_arb_loss && !arb_loss_retry_enable)
      && !sw_trq_set[ev_buf] |=> !transmit_request_flag[$past(ev_buf)])
    else $error("request not cleared in single-shot");
  arb_retry_a: assert property (
    mode_reg == cdm_normal && ev_arb_loss && !ev_tx_ok && !ev_error
      && transmit_request_flag[ev_buf] |=> transmit_request_flag[$past(ev_buf)])
    else $error("request dropped after arbitration loss");
  valid_flag_a: assert property (
    ev_rx_good && mode_reg != cdm_init |=> valid_reg)
    else $error("valid flag not set");
  proto_err_a: assert property (
    perr_ev && mode_reg != cdm_init |=> int_status_reg[`CDM_INT_PERR_BIT]
      && last_error_code == $past(ev_err_code))
    else $error("protocol error not recorded");
  tx_done_irq_a: assert property (
    ev_tx_ok && tx_mode(mode_reg) && int_enable_reg[`CDM_INT_TXDONE_BIT]
      && !(wr_en && paddr == `CDM_OFS_IE) |=> int_status_reg[`CDM_INT_TXDONE_BIT] ##1 tx_irq)
    else $error("transmit interrupt missing");
  internal_ack_a: assert property (
    mode_reg == cdm_rx_only && core_ack_slot |=> !core_rx_bit && bus_tx_pin)
    else $error("internal acknowledge missing");
  loopback_a: assert property (
    mode_reg == cdm_self_test |=> core_rx_bit == $past(core_tx_bit))
    else $error("self-test loopback broken");
endmodule // cdm_diag

// file: bench/cdm_core_model.sv
`timescale 1ns/1ps
module cdm_core_model (
  input wire logic mclk,
  input wire logic rx_word_ready,
  output logic bus_rx_pin,
  output logic core_tx_bit,
  output logic core_ack_slot,
  output logic ev_tx_ok,
  output logic ev_arb_loss,
  output logic ev_error,
  output cdm_pkg::cdm_lec_t ev_err_code,
  output logic [1:0] ev_buf,
  output logic ev_rx_good,
  output logic rx_word_valid,
  output logic [31:0] rx_word
);
  import cdm_pkg::*;
  initial
  begin
    {ev_tx_ok, ev_arb_loss, ev_error, ev_rx_good, rx_word_valid, core_ack_slot} = 6'h00;
    {bus_rx_pin, core_tx_bit, ev_err_code, ev_buf, rx_word} = 39'h0;
    bus_rx_pin = 1'b1;
  end
  // one-cycle core event; index and code scrambled once released
  task evt(input int k, input logic [1:0] b, input cdm_lec_t c);
    @(posedge mclk);
    ev_buf <= b;
    ev_err_code <= c;
    ev_tx_ok <= (k == 0);
    ev_arb_loss <= (k == 1);
    ev_error <= (k == 2);
    ev_rx_good <= (k == 3);
    @(posedge mclk);
    {ev_tx_ok, ev_arb_loss, ev_error, ev_rx_good} <= 4'h0;
    ev_buf <= ~b;
    ev_err_code <= ~c;
  endtask
  // bus level, wanted tx bit and ack slot; a falling rx level wakes a sleeper unless rx_pin_is_port is set
  task line(input logic rx, input logic tx, input logic ack);
    @(posedge mclk);
    bus_rx_pin <= rx;
    core_tx_bit <= tx;
    core_ack_slot <= ack;
  endtask
  // receive word held until taken
  task push(input logic [31:0] w);
    @(posedge mclk);
    rx_word_valid <= 1'b1;
    rx_word <= w;
    do
    begin
      @(posedge mclk);
    end while (rx_word_ready !== 1'b1);
    rx_word_valid <= 1'b0;
    rx_word <= ~w;
  endtask
endmodule // cdm_core_model

// file: bench/cdm_diag_tb.sv
`timescale 1ns/1ps
module cdm_diag_tb;
  import cdm_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rx_word;
  logic bus_tx_pin, bus_rx_pin, core_tx_bit, core_ack_slot, core_rx_bit;
  logic ev_tx_ok, ev_arb_loss, ev_error, ev_rx_good, rx_word_valid, rx_word_ready;
  logic tx_enable, retry_arb_enable, retry_err_enable, store_enable, abt_enable;
  logic bus_off, tx_irq, sleep_active, rx_pin_is_port, wake_pulse;
  logic [1:0] ev_buf;
  logic [3:0] transmit_request_flag;
  cdm_lec_t ev_err_code;
  logic [10:0] mt [8];
  int n_fail = 0;
  int checks = 0;
  int n_wake = 0;
  cdm_diag u_cdm_diag (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_tx_pin(bus_tx_pin), .bus_rx_pin(bus_rx_pin), .core_tx_bit(core_tx_bit),
    .core_ack_slot(core_ack_slot), .core_rx_bit(core_rx_bit), .ev_tx_ok(ev_tx_ok),
    .ev_arb_loss(ev_arb_loss), .ev_error(ev_error), .ev_err_code(ev_err_code), .ev_buf(ev_buf),
    .ev_rx_good(ev_rx_good), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_word_ready(rx_word_ready), .tx_enable(tx_enable), .retry_arb_enable(retry_arb_enable),
    .retry_err_enable(retry_err_enable), .store_enable(store_enable), .abt_enable(abt_enable),
    .transmit_request_flag(transmit_request_flag), .bus_off(bus_off), .tx_irq(tx_irq),
    .sleep_active(sleep_active), .rx_pin_is_port(rx_pin_is_port), .wake_pulse(wake_pulse));
  cdm_core_model u_cdm_core_model (.mclk(mclk), .rx_word_ready(rx_word_ready),
    .bus_rx_pin(bus_rx_pin), .core_tx_bit(core_tx_bit), .core_ack_slot(core_ack_slot),
    .ev_tx_ok(ev_tx_ok), .ev_arb_loss(ev_arb_loss), .ev_error(ev_error),
    .ev_err_code(ev_err_code), .ev_buf(ev_buf), .ev_rx_good(ev_rx_good),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (wake_pulse === 1'b1)
      n_wake <= n_wake + 1;
  end
  task results;
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    results;
  end
  initial
  begin
    // {retry bit, mode, tx, retry arb, retry err, store, block, pin, core rx}
    mt = '{11'h003, 11'h0f9, 11'h4f9, 11'h1fd, 11'h149, 11'h569, 11'h30b, 11'h3fa};
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    sleep_active = 1'b0;
    rx_pin_is_port = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({30'h0, bus_tx_pin, rx_word_ready}, 32'h3);
    for (int a = 0; a <= 8'h14; a += 4)
      rchk(a[7:0], 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    u_cdm_core_model.line(1'b1, 1'b0, 1'b0);
    // codes never mix single-shot with block send
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h00, {28'h0, mt[i][10:7]});
      settle;
      chk({25'h0, tx_enable, retry_arb_enable, retry_err_enable, store_enable, abt_enable,
        bus_tx_pin, core_rx_bit}, {25'h0, mt[i][6:0]});
      rchk(8'h00, {28'h0, mt[i][10:7]});
    end
    wr(8'h00, 32'h5);
    rchk(8'h00, 32'h7);
    wr(8'h00, 32'h6);
    u_cdm_core_model.line(1'b1, 1'b0, 1'b1);
    settle;
    chk({30'h0, bus_tx_pin, core_rx_bit}, 32'h2);
    u_cdm_core_model.line(1'b1, 1'b1, 1'b0);
    wr(8'h14, 32'h1);
    u_cdm_core_model.evt(2, 2'h0, 3'h1);
    rchk(8'h14, 32'h1);
    rchk(8'h10, 32'h0);
    u_cdm_core_model.evt(3, 2'h0, 3'h0);
    rchk(8'h00, 32'h106);
    wr(8'h00, 32'h106);
    rchk(8'h00, 32'h6);
    wr(8'h00, 32'h1);
    for (int c = 1; c <= 5; c++)
    begin
      u_cdm_core_model.evt(2, 2'h1, c[2:0]);
      rchk(8'h0c, c);
      rchk(8'h04, 32'h8);
    end
    rchk(8'h10, 32'h28);
    u_cdm_core_model.evt(0, 2'h0, 3'h0);
    rchk(8'h10, 32'h27);
    rchk(8'h14, 32'h0);
    repeat (30) u_cdm_core_model.evt(2, 2'h1, 3'h2);
    rchk(8'h10, 32'h1ff);
    chk({31'h0, bus_off}, 32'h1);
    wr(8'h00, 32'h0);
    settle;
    chk({31'h0, bus_off}, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h8);
    u_cdm_core_model.evt(1, 2'h3, 3'h0);
    rchk(8'h14, 32'h8);
    u_cdm_core_model.evt(0, 2'h3, 3'h0);
    rchk(8'h14, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h1f);
    rchk(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h14, 32'h7);
    u_cdm_core_model.evt(1, 2'h1, 3'h0);
    rchk(8'h04, 32'h10);
    rchk(8'h14, 32'h5);
    u_cdm_core_model.evt(2, 2'h2, 3'h4);
    rchk(8'h04, 32'h18);
    rchk(8'h0c, 32'h4);
    rchk(8'h14, 32'h1);
    u_cdm_core_model.evt(0, 2'h0, 3'h0);
    rchk(8'h04, 32'h19);
    rchk(8'h14, 32'h0);
    chk({31'h0, tx_irq}, 32'h1);
    wr(8'h04, 32'h19);
    settle;
    chk({31'h0, tx_irq}, 32'h0);
    wr(8'h08, 32'h0);
    u_cdm_core_model.evt(0, 2'h0, 3'h0);
    settle;
    chk({31'h0, tx_irq}, 32'h0);
    wr(8'h00, 32'ha);
    wr(8'h14, 32'h2);
    u_cdm_core_model.evt(1, 2'h1, 3'h0);
    rchk(8'h14, 32'h2);
    u_cdm_core_model.evt(2, 2'h1, 3'h3);
    rchk(8'h14, 32'h0);
    wr(8'h00, 32'h1);
    for (int i = 0; i < 8; i++)
      u_cdm_core_model.push(32'h5a000000 + i);
    settle;
    chk({31'h0, rx_word_ready}, 32'h0);
    rchk(8'h00, 32'h201);
    for (int i = 0; i < 8; i++)
      rchk(8'h18, 32'h5a000000 + i);
    rchk(8'h18, 32'h0);
    rchk(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    u_cdm_core_model.push(32'h77);
    rchk(8'h18, 32'h0);
    u_cdm_core_model.evt(3, 2'h0, 3'h0);
    rchk(8'h00, 32'h0);
    wr(8'h00, 32'h7);
    @(posedge mclk);
    sleep_active <= 1'b1;
    u_cdm_core_model.line(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    chk(n_wake, 32'h1);
    rx_pin_is_port <= 1'b1;
    u_cdm_core_model.line(1'b1, 1'b1, 1'b0);
    u_cdm_core_model.line(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    chk(n_wake, 32'h1);
    results;
  end
endmodule // cdm_diag_tb
